/* ssm_pkg.sv */
// Constants and types for the synchronous serial master channel
// Summary of operation
// - Error request raised only by receive overrun
// - Clock source 00b drives internal clock out
// - Mode bit 1 selects clock-synchronous operation
// - Prescale 00b feeds peripheral clock undivided
// - Plain interface, no data inversion at 0
// - Bit order 0 shifts LSB first
// - Divisor 149 at 60 MHz gives 100k
// - Priority register 05h yields level 5
// - Function 0Ah routes pins, writes guarded
`default_nettype none
package ssm_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] CLKSRC_INTERNAL = 2'h0;
  localparam logic [7:0] PROTECT_KEY = 8'hA5;
  localparam int PROTECT_STOP_POS = 1;
  localparam logic STOP_RESET = 1'h1;
  localparam int PINSEL_LOCK_POS = 7;
  localparam int PINSEL_WE_POS = 6;
  localparam logic [7:0] PINSEL_SERIAL = 8'h0A;
  localparam logic [7:0] PINSEL_RESET = 8'h00;
  localparam logic [3:0] PRIO_RESET = 4'h0;
  typedef enum logic [0:0] {
    SSM_IDLE = 1'b0,
    SSM_SHIFT = 1'b1
  } ssm_state_e;
endpackage : ssm_pkg
`default_nettype wire

/* ssm_channel.sv */
// Synchronous serial master channel with its transmit FIFO
`default_nettype none
module ssm_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Fill side
  input wire logic wr_valid,
  input wire logic [W-1:0] wr_data,
  output logic wr_ready,
  // Drain side
  output logic rd_valid,
  output logic [W-1:0] rd_data,
  input wire logic rd_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign wr_ready = (cnt_q != (AW+1)'(D));
  assign rd_valid = (cnt_q != '0);
  assign rd_data = mem_q[rp_q];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wp_q] <= wr_data;
    end
  end
endmodule : ssm_fifo

module ssm_channel
  import ssm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Module stop and its protect key
  input wire logic protect_key_wr,
  input wire logic [15:0] protect_key_reg,
  input wire logic stop_wr,
  input wire logic stop_wdata,
  output logic serial_stop_bit,
  // Control and mode
  input wire logic transmit_enable,
  input wire logic rx_on,
  input wire logic tx_empty_irq_on,
  input wire logic rx_full_irq_on,
  input wire logic tx_done_irq_on,
  input wire logic [1:0] clock_source,
  input wire logic sync_mode_sel,
  input wire logic [1:0] prescale_sel,
  input wire logic smartcard_sel,
  input wire logic data_invert,
  input wire logic bit_order,
  input wire logic [7:0] baud_divisor,
  // Transmit data stream
  input wire logic tx_valid,
  input wire logic [DATA_W-1:0] tx_data,
  output logic tx_ready,
  output logic tx_done,
  // Receive data
  input wire logic rx_read,
  input wire logic overrun_clr,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_full,
  output logic rx_overrun,
  // Serial requests
  output logic tx_empty_request,
  output logic rx_full_request,
  output logic tx_done_request,
  output logic error_request,
  // Interrupt controller
  input wire logic prio_wr,
  input wire logic [3:0] prio_wdata,
  input wire logic grp_prio_wr,
  input wire logic [3:0] grp_prio_wdata,
  input wire logic tx_pending_clr,
  input wire logic [1:0] irq_enable_bank,
  input wire logic [1:0] group_irq_enable,
  output logic tx_irq_pending,
  output logic [3:0] tx_irq_level,
  output logic [3:0] grp_irq_level,
  // Pin selection
  input wire logic pinsel_wr,
  input wire logic [7:0] pinsel_wdata,
  input wire logic data_pin_wr,
  input wire logic clk_pin_wr,
  input wire logic [7:0] pin_func_wdata,
  output logic pinsel_lock,
  output logic pinsel_write_on,
  // Port fallback
  input wire logic [1:0] port_out_value,
  input wire logic [1:0] port_dir,
  input wire logic [1:0] port_periph_sel,
  // Pins
  input wire logic serial_in_pin,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe
);
  logic stop_q, stop_d, key_ok_q, key_ok_d;
  always_comb begin
    key_ok_d = key_ok_q;
    stop_d = stop_q;
    if (protect_key_wr && protect_key_reg[15:8] == PROTECT_KEY) begin
      key_ok_d = protect_key_reg[PROTECT_STOP_POS];
    end
    if (stop_wr && key_ok_q) begin
      stop_d = stop_wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stop_q <= STOP_RESET;
      key_ok_q <= 1'b0;
    end else begin
      stop_q <= stop_d;
      key_ok_q <= key_ok_d;
    end
  end
  assign serial_stop_bit = stop_q;

  logic lock_q, lock_d, pwe_q, pwe_d;
  logic [7:0] dfunc_q, dfunc_d, cfunc_q, cfunc_d;
  always_comb begin
    lock_d = lock_q;
    pwe_d = pwe_q;
    dfunc_d = dfunc_q;
    cfunc_d = cfunc_q;
    if (pinsel_wr) begin
      lock_d = pinsel_wdata[PINSEL_LOCK_POS];
      if (!lock_q) begin
        pwe_d = pinsel_wdata[PINSEL_WE_POS];
      end
    end
    if (pwe_q && data_pin_wr) begin
      dfunc_d = pin_func_wdata;
    end
    if (pwe_q && clk_pin_wr) begin
      cfunc_d = pin_func_wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      lock_q <= 1'b1;
      pwe_q <= 1'b0;
      dfunc_q <= PINSEL_RESET;
      cfunc_q <= PINSEL_RESET;
    end else begin
      lock_q <= lock_d;
      pwe_q <= pwe_d;
      dfunc_q <= dfunc_d;
      cfunc_q <= cfunc_d;
    end
  end
  assign pinsel_lock = lock_q;
  assign pinsel_write_on = pwe_q;

  // Channel may run only in synchronous, plain, internally clocked mode
  logic run;
  assign run = !stop_q && sync_mode_sel && !smartcard_sel
    && clock_source == CLKSRC_INTERNAL;

  ssm_state_e st_q, st_d;
  logic [5:0] pre_q, pre_d, pre_lim;
  logic [7:0] div_q, div_d;
  logic ph_q, ph_d, half_tick;
  always_comb begin
    unique case (prescale_sel)
      2'h0: pre_lim = 6'h00;
      2'h1: pre_lim = 6'h03;
      2'h2: pre_lim = 6'h0F;
      2'h3: pre_lim = 6'h3F;
    endcase
  end
  // Half bit is 2*(divisor+1)*4^n clocks: 149 at 60 MHz is 100k
  always_comb begin
    pre_d = '0;
    div_d = '0;
    ph_d = 1'b0;
    half_tick = 1'b0;
    if (st_q == SSM_SHIFT) begin
      pre_d = pre_q + 6'h01;
      div_d = div_q;
      ph_d = ph_q;
      if (pre_q == pre_lim) begin
        pre_d = '0;
        div_d = div_q + 8'h01;
        if (div_q == baud_divisor) begin
          div_d = '0;
          ph_d = !ph_q;
          half_tick = ph_q;
        end
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pre_q <= '0;
      div_q <= '0;
      ph_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      div_q <= div_d;
      ph_q <= ph_d;
    end
  end

  logic fifo_valid, pop, go;
  logic [DATA_W-1:0] fifo_data;
  ssm_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) ssm_fifo_inst (
    .core_clk(core_clk),
    .reset(reset),
    .wr_valid(tx_valid),
    .wr_data(tx_data),
    .wr_ready(tx_ready),
    .rd_valid(fifo_valid),
    .rd_data(fifo_data),
    .rd_ready(pop)
  );

  function automatic logic pick(input logic [DATA_W-1:0] d,
                                input logic [2:0] i, input logic msb,
                                input logic inv);
    pick = (msb ? d[LAST_BIT - i] : d[i]) ^ inv;
  endfunction : pick

  logic [DATA_W-1:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic sclk_q, sclk_d, dout_q, dout_d, done_q, done_d, rise;
  assign go = run && transmit_enable && fifo_valid;
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    sclk_d = sclk_q;
    dout_d = dout_q;
    done_d = done_q;
    pop = 1'b0;
    rise = 1'b0;
    unique case (st_q)
      SSM_IDLE: begin
        if (go) begin
          pop = 1'b1;
          st_d = SSM_SHIFT;
        end
      end
      SSM_SHIFT: begin
        if (!run || !transmit_enable) begin
          st_d = SSM_IDLE;
          sclk_d = 1'b1;
        end else if (half_tick && !sclk_q) begin
          sclk_d = 1'b1;
          rise = 1'b1;
        end else if (half_tick) begin
          if (bit_q != LAST_BIT) begin
            bit_d = bit_q + 3'h1;
            sclk_d = 1'b0;
            dout_d = pick(sh_q, bit_d, bit_order, data_invert);
          end else if (go) begin
            pop = 1'b1;
          end else begin
            st_d = SSM_IDLE;
            done_d = 1'b1;
          end
        end
      end
    endcase
    if (pop) begin
      sh_d = fifo_data;
      bit_d = '0;
      sclk_d = 1'b0;
      done_d = 1'b0;
      dout_d = pick(fifo_data, 3'h0, bit_order, data_invert);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= SSM_IDLE;
      sh_q <= '0;
      bit_q <= '0;
      sclk_q <= 1'b1;
      dout_q <= 1'b1;
      done_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      sclk_q <= sclk_d;
      dout_q <= dout_d;
      done_q <= done_d;
    end
  end
  assign tx_done = done_q;
  assign tx_empty_request = pop && tx_empty_irq_on;
  assign tx_done_request = done_q && tx_done_irq_on;

  logic s1_q, s2_q, s3_q, lvl_q, lvl_d, ovr_evt, rxe;
  logic [DATA_W-1:0] rsh_q, rsh_d, rdat_q, rdat_d;
  logic [2:0] rcnt_q, rcnt_d;
  logic full_q, full_d, ovr_q, ovr_d;
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    rsh_d = rsh_q;
    rcnt_d = rcnt_q;
    rdat_d = rdat_q;
    full_d = full_q && !rx_read;
    ovr_d = ovr_q && !overrun_clr;
    ovr_evt = 1'b0;
    rxe = 1'b0;
    if (rise && rx_on) begin
      rsh_d = bit_order ? {rsh_q[DATA_W-2:0], lvl_q ^ data_invert}
                        : {lvl_q ^ data_invert, rsh_q[DATA_W-1:1]};
      rcnt_d = rcnt_q + 3'h1;
      if (rcnt_q == LAST_BIT) begin
        if (full_q) begin
          ovr_evt = 1'b1;
          ovr_d = 1'b1;
        end else begin
          rxe = 1'b1;
          full_d = 1'b1;
          rdat_d = rsh_d;
        end
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
      rsh_q <= '0;
      rcnt_q <= '0;
      rdat_q <= '0;
      full_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      s1_q <= serial_in_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rsh_q <= rsh_d;
      rcnt_q <= rcnt_d;
      rdat_q <= rdat_d;
      full_q <= full_d;
      ovr_q <= ovr_d;
    end
  end
  assign rx_data = rdat_q;
  assign rx_full = full_q;
  assign rx_overrun = ovr_q;
  assign rx_full_request = rxe && rx_full_irq_on;
  assign error_request = ovr_evt && rx_full_irq_on;

  logic [3:0] prio_q, prio_d, gprio_q, gprio_d;
  logic pend_q, pend_d, grp_src;
  assign grp_src = (tx_done_request && group_irq_enable[0])
    || (ovr_q && rx_full_irq_on && group_irq_enable[1]);
  always_comb begin
    prio_d = prio_wr ? prio_wdata : prio_q;
    gprio_d = grp_prio_wr ? grp_prio_wdata : gprio_q;
    pend_d = tx_empty_request || (pend_q && !tx_pending_clr);
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prio_q <= PRIO_RESET;
      gprio_q <= PRIO_RESET;
      pend_q <= 1'b0;
    end else begin
      prio_q <= prio_d;
      gprio_q <= gprio_d;
      pend_q <= pend_d;
    end
  end
  assign tx_irq_pending = pend_q;
  assign tx_irq_level = (pend_q && irq_enable_bank[0]) ? prio_q : '0;
  assign grp_irq_level = (grp_src && irq_enable_bank[1]) ? gprio_q : '0;

  logic dper, cper;
  assign dper = port_periph_sel[0] && dfunc_q == PINSEL_SERIAL;
  assign cper = port_periph_sel[1] && cfunc_q == PINSEL_SERIAL;
  assign serial_out_pin_o = dper ? dout_q : port_out_value[0];
  assign serial_out_pin_oe = dper ? transmit_enable : port_dir[0];
  assign serial_clock_pin_o = cper ? sclk_q : port_out_value[1];
  assign serial_clock_pin_oe = cper
    ? (transmit_enable && clock_source == CLKSRC_INTERNAL)
    : port_dir[1];

  logic [15:0] low_cnt_q;
  always_ff @(posedge core_clk) begin
    if (reset || sclk_q) begin
      low_cnt_q <= 16'h0001;
    end else begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_load;
    st_q == SSM_IDLE && pop;
  endsequence
  sequence s_first_low;
    !sclk_q && dout_q == $past(fifo_data[0] ^ data_invert);
  endsequence
  AST_STOP_INERT: assert property (stop_q |-> ##1 st_q == SSM_IDLE)
    else $error("stopped channel left idle");
  AST_STOP_LOCKED: assert property (stop_wr && !key_ok_q |=>
    stop_q == $past(stop_q)) else $error("stop bit changed while locked");
  AST_PINSEL_GUARD: assert property ((data_pin_wr || clk_pin_wr)
    && !pwe_q |=> $stable(dfunc_q) && $stable(cfunc_q))
    else $error("pin function written while protected");
  AST_IDLE_HIGH: assert property (st_q == SSM_IDLE && !$past(pop)
    |-> sclk_q) else $error("shift clock low while idle");
  AST_LSB_FIRST: assert property (s_load and !bit_order
    |=> s_first_low) else $error("first bit not the low bit");
  AST_HALF_BIT: assert property ($rose(sclk_q) && st_q == SSM_SHIFT
    && prescale_sel == 2'h0 && $stable(baud_divisor) |->
    $past(low_cnt_q) == 16'(2 * ({8'h00, baud_divisor} + 16'h0001)))
    else $error("half bit length wrong");
  AST_ERR_OVERRUN: assert property (error_request |-> full_q ##1 ovr_q)
    else $error("error request without overrun");
  AST_PRIO_LEVEL: assert property (pend_q && irq_enable_bank[0]
    |-> tx_irq_level == prio_q) else $error("priority level mismatch");
  AST_SYNC_ONLY: assert property (tx_empty_request |-> sync_mode_sel
    && !smartcard_sel) else $error("transmit outside sync mode");
endmodule : ssm_channel
`default_nettype wire

/* ssm_rx_model.sv */
// Far-side receiver clocked by the channel's shift clock
`default_nettype none
module ssm_rx_model (
  // Serial lines
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  output logic miso,
  // Reply byte and count of bytes taken
  input wire logic [7:0] reply,
  output int nbytes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [0:63];
  logic [7:0] sh;
  int nb;
  initial begin
    nbytes = 0;
    nb = 0;
    sh = 8'h00;
    miso = 1'b1;
  end
  // Samples on the rising edge, first bit ends in bit 0
  always @(posedge sclk) begin
    if (!rst) begin
      sh = {sdata, sh[7:1]};
      nb = nb + 1;
      if (nb == 8) begin
        got[nbytes % 64] = sh;
        nbytes = nbytes + 1;
        nb = 0;
      end
    end
  end
  // Reply bit changes while the clock is low
  always @(negedge sclk) begin
    miso = reply[nb % 8];
  end
endmodule : ssm_rx_model
`default_nettype wire

/* ssm_channel_tb.sv */
// Self-checking bench for the synchronous serial master channel
`default_nettype none
module ssm_channel_tb;
  import ssm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, protect_key_wr, stop_wr, stop_wdata;
  logic [15:0] protect_key_reg;
  logic transmit_enable, rx_on, tx_empty_irq_on, rx_full_irq_on;
  logic tx_done_irq_on, sync_mode_sel, smartcard_sel, data_invert;
  logic bit_order, tx_valid, rx_read, overrun_clr, prio_wr, grp_prio_wr;
  logic tx_pending_clr, pinsel_wr, data_pin_wr, clk_pin_wr;
  logic [1:0] clock_source, prescale_sel, irq_enable_bank;
  logic [1:0] group_irq_enable, port_out_value, port_dir, port_periph_sel;
  logic [7:0] baud_divisor, tx_data, pinsel_wdata, pin_func_wdata;
  logic [3:0] prio_wdata, grp_prio_wdata;
  logic serial_stop_bit, tx_ready, tx_done, rx_full, rx_overrun;
  logic tx_empty_request, rx_full_request, tx_done_request, error_request;
  logic tx_irq_pending, pinsel_lock, pinsel_write_on;
  logic serial_out_pin_o, serial_out_pin_oe;
  logic serial_clock_pin_o, serial_clock_pin_oe;
  logic [7:0] rx_data, got_b;
  logic [3:0] tx_irq_level, grp_irq_level;
  logic last_s;
  wire serial_in_pin;
  int miscompares, n_compared, n_err, n_txe, n_rxf, i, k;
  int stamps[$];
  // Both lines carry pull-ups
  wire sclk_w = serial_clock_pin_oe ? serial_clock_pin_o : 1'b1;
  wire sout_w = serial_out_pin_oe ? serial_out_pin_o : 1'b1;

  ssm_channel ssm_channel_inst (
    .core_clk(core_clk), .reset(reset), .protect_key_wr(protect_key_wr),
    .protect_key_reg(protect_key_reg), .stop_wr(stop_wr),
    .stop_wdata(stop_wdata), .serial_stop_bit(serial_stop_bit),
    .transmit_enable(transmit_enable), .rx_on(rx_on),
    .tx_empty_irq_on(tx_empty_irq_on), .rx_full_irq_on(rx_full_irq_on),
    .tx_done_irq_on(tx_done_irq_on), .clock_source(clock_source),
    .sync_mode_sel(sync_mode_sel), .prescale_sel(prescale_sel),
    .smartcard_sel(smartcard_sel), .data_invert(data_invert),
    .bit_order(bit_order), .baud_divisor(baud_divisor),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .tx_done(tx_done), .rx_read(rx_read), .overrun_clr(overrun_clr),
    .rx_data(rx_data), .rx_full(rx_full), .rx_overrun(rx_overrun),
    .tx_empty_request(tx_empty_request), .rx_full_request(rx_full_request),
    .tx_done_request(tx_done_request), .error_request(error_request),
    .prio_wr(prio_wr), .prio_wdata(prio_wdata), .grp_prio_wr(grp_prio_wr),
    .grp_prio_wdata(grp_prio_wdata), .tx_pending_clr(tx_pending_clr),
    .irq_enable_bank(irq_enable_bank), .group_irq_enable(group_irq_enable),
    .tx_irq_pending(tx_irq_pending), .tx_irq_level(tx_irq_level),
    .grp_irq_level(grp_irq_level), .pinsel_wr(pinsel_wr),
    .pinsel_wdata(pinsel_wdata), .data_pin_wr(data_pin_wr),
    .clk_pin_wr(clk_pin_wr), .pin_func_wdata(pin_func_wdata),
    .pinsel_lock(pinsel_lock), .pinsel_write_on(pinsel_write_on),
    .port_out_value(port_out_value), .port_dir(port_dir),
    .port_periph_sel(port_periph_sel), .serial_in_pin(serial_in_pin),
    .serial_out_pin_o(serial_out_pin_o),
    .serial_out_pin_oe(serial_out_pin_oe),
    .serial_clock_pin_o(serial_clock_pin_o),
    .serial_clock_pin_oe(serial_clock_pin_oe)
  );
  ssm_rx_model ssm_rx_model_inst (.rst(reset), .sclk(sclk_w),
    .sdata(sout_w), .miso(serial_in_pin), .reply(8'h5C), .nbytes());

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (error_request === 1'b1) n_err++;
    if (tx_empty_request === 1'b1) n_txe++;
    if (rx_full_request === 1'b1) n_rxf++;
  end

  task summarize;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task push_n(input int n, input logic [7:0] b0);
    int j;
    int w;
    for (j = 0; j < n; j++) begin
      tx_valid <= 1'b1;
      tx_data <= b0 + 8'(j);
      @(negedge core_clk);
      for (w = 0; w < 9000 && tx_ready !== 1'b1; w++) @(negedge core_clk);
      if (w == 9000) miscompares++;
      if (w == 9000) summarize();
      @(posedge core_clk);
    end
    tx_valid <= 1'b0;
  endtask : push_n
  task wait_rx(input int n);
    int w;
    for (w = 0; w < 20000; w++) begin
      @(negedge core_clk);
      if (ssm_rx_model_inst.nbytes >= n && tx_done === 1'b1) break;
    end
    if (w == 20000) miscompares++;
    if (w == 20000) summarize();
    @(posedge core_clk);
  endtask : wait_rx
  task psel(input logic [7:0] v);
    pinsel_wr <= 1'b1;
    pinsel_wdata <= v;
    tick(1);
    pinsel_wr <= 1'b0;
    tick(1);
  endtask : psel

  initial begin
    {protect_key_wr, protect_key_reg, stop_wr, stop_wdata, transmit_enable,
     rx_on, tx_empty_irq_on, rx_full_irq_on, tx_done_irq_on, clock_source,
     sync_mode_sel, prescale_sel, smartcard_sel, data_invert, bit_order,
     baud_divisor, tx_valid, tx_data, rx_read, overrun_clr, prio_wr,
     prio_wdata, grp_prio_wr, grp_prio_wdata, tx_pending_clr,
     irq_enable_bank, group_irq_enable, pinsel_wr, pinsel_wdata,
     data_pin_wr, clk_pin_wr, pin_func_wdata, port_periph_sel} = '0;
    port_out_value = 2'h3;
    port_dir = 2'h3;
    reset = 1'b1;
    tick(6);
    reset <= 1'b0;
    tick(2);
    chk("reset state", 16'h01BF, 16'({serial_stop_bit, pinsel_lock,
      pinsel_write_on, tx_done, tx_ready, serial_out_pin_o, serial_out_pin_oe,
      serial_clock_pin_o, serial_clock_pin_oe}));
    // Stop write without the key is ignored
    stop_wr <= 1'b1;
    tick(1);
    stop_wr <= 1'b0;
    tick(1);
    chk("stop locked", 16'h1, 16'(serial_stop_bit));
    sync_mode_sel <= 1'b1;
    baud_divisor <= 8'h03;
    prio_wr <= 1'b1;
    prio_wdata <= 4'h5;
    grp_prio_wr <= 1'b1;
    grp_prio_wdata <= 4'h5;
    tick(1);
    prio_wr <= 1'b0;
    grp_prio_wr <= 1'b0;
    tick(16);
    tx_pending_clr <= 1'b1;
    tick(1);
    tx_pending_clr <= 1'b0;
    irq_enable_bank <= 2'h1;
    tx_empty_irq_on <= 1'b1;
    transmit_enable <= 1'b1;
    psel(8'h00);
    psel(8'h40);
    chk("pinsel open", 16'h1, 16'({pinsel_lock, pinsel_write_on}));
    data_pin_wr <= 1'b1;
    clk_pin_wr <= 1'b1;
    pin_func_wdata <= 8'h0A;
    tick(1);
    data_pin_wr <= 1'b0;
    clk_pin_wr <= 1'b0;
    psel(8'h00);
    psel(8'h80);
    chk("pinsel shut", 16'h2, 16'({pinsel_lock, pinsel_write_on}));
    // Refused while write protection is back on
    data_pin_wr <= 1'b1;
    pin_func_wdata <= 8'h00;
    tick(1);
    data_pin_wr <= 1'b0;
    port_periph_sel <= 2'h3;
    // Fill the buffer while the channel is still stopped
    push_n(16, 8'h30);
    @(negedge core_clk);
    chk("fifo full", 16'h0, 16'(tx_ready));
    tick(50);
    chk("inert", 16'h1, {15'(ssm_rx_model_inst.nbytes), tx_done});
    protect_key_wr <= 1'b1;
    protect_key_reg <= 16'hA502;
    tick(1);
    protect_key_wr <= 1'b0;
    stop_wr <= 1'b1;
    tick(1);
    stop_wr <= 1'b0;
    protect_key_wr <= 1'b1;
    protect_key_reg <= 16'hA500;
    tick(1);
    protect_key_wr <= 1'b0;
    tick(1);
    chk("stop bit", 16'h0, 16'(serial_stop_bit));
    wait_rx(16);
    for (i = 0; i < 16; i++) begin
      got_b = ssm_rx_model_inst.got[i];
      chk("byte", 16'(8'h30 + i), 16'(got_b));
    end
    chk("empty requests", 16'd16, 16'(n_txe));
    chk("tx level", 16'h5, 16'(tx_irq_level));
    tx_pending_clr <= 1'b1;
    tick(1);
    tx_pending_clr <= 1'b0;
    tick(1);
    chk("tx level clr", 16'h0, 16'(tx_irq_level));
    bit_order <= 1'b1;
    push_n(1, 8'hC1);
    wait_rx(17);
    got_b = ssm_rx_model_inst.got[16];
    chk("msb first", 16'h83, 16'(got_b));
    bit_order <= 1'b0;
    chk("no error yet", 16'h0, 16'(n_err));
    rx_on <= 1'b1;
    rx_full_irq_on <= 1'b1;
    push_n(2, 8'hA0);
    wait_rx(19);
    got_b = ssm_rx_model_inst.got[18];
    chk("byte A1", 16'hA1, 16'(got_b));
    chk("rx data", 16'h5C, 16'(rx_data));
    chk("overrun", 16'h3, 16'({rx_full, rx_overrun}));
    chk("error pulses", 16'h1, 16'(n_err));
    group_irq_enable <= 2'h2;
    irq_enable_bank <= 2'h2;
    tick(2);
    chk("error group", 16'h5, 16'(grp_irq_level));
    rx_read <= 1'b1;
    overrun_clr <= 1'b1;
    tick(1);
    rx_read <= 1'b0;
    overrun_clr <= 1'b0;
    tick(1);
    chk("rx cleared", 16'h0, 16'({rx_full, rx_overrun, grp_irq_level}));
    tx_done_irq_on <= 1'b1;
    group_irq_enable <= 2'h1;
    tick(2);
    chk("done group", 16'h15, 16'({tx_done_request, grp_irq_level}));
    chk("tx pending", 16'h1, 16'(tx_irq_pending));
    // Inverted data at prescale 4, divisor 0
    data_invert <= 1'b1;
    prescale_sel <= 2'h1;
    baud_divisor <= 8'h00;
    tick(16);
    push_n(1, 8'h3C);
    wait_rx(20);
    got_b = ssm_rx_model_inst.got[19];
    chk("inverted tx", 16'hC3, 16'(got_b));
    chk("inverted rx", 16'hA3, 16'(rx_data));
    chk("rx requests", 16'h0201, 16'({8'(n_rxf), 8'(n_err)}));
    data_invert <= 1'b0;
    prescale_sel <= 2'h0;
    baud_divisor <= 8'd149;
    tick(600);
    push_n(1, 8'h55);
    last_s = 1'b1;
    for (k = 0; k < 5000; k++) begin
      @(negedge core_clk);
      if (sclk_w === 1'b1 && last_s === 1'b0) stamps.push_back(k);
      last_s = sclk_w;
    end
    chk("bit period", 16'd600, 16'(stamps[1] - stamps[0]));
    summarize();
  end
endmodule : ssm_channel_tb
`default_nettype wire
